// ---- hdl/pcl_map.svh ----
/*
 * Register map, field positions, reset values and source-select codes
 * for the current-limit source-select stage of the PWM generators.
 * Assumes a 16-bit register port whose address counts whole registers.
 */
`ifndef PCL_MAP_SVH
`define PCL_MAP_SVH

// register addresses, one register per index
`define PCL_CTRL_BASE   8'h00
`define PCL_STAT_BASE   8'h10

// control register fields
`define PCL_CTRL_RST    16'h0000
`define PCL_CTRL_WMASK  16'h1FFF
`define PCL_SRC_HI      12
`define PCL_SRC_LO      9
`define PCL_POL_BIT     8
`define PCL_MODE_BIT    7

// status register fields
`define PCL_ST_LEVEL    0
`define PCL_ST_ACTIVE   1
`define PCL_ST_RSVD     2
`define PCL_ST_HIT      3

// source-select codes
`define PCL_SEL_CMP1    4'h0
`define PCL_SEL_CMP2    4'h1
`define PCL_SEL_CMP3    4'h2
`define PCL_SEL_CMP4    4'h3
`define PCL_SEL_SHRD1   4'h8
`define PCL_SEL_SHRD2   4'h9
`define PCL_SEL_SHRD3   4'hA
`define PCL_SEL_SHRD4   4'hB
`define PCL_SEL_IND2    4'hD
`define PCL_SEL_IND4    4'hF

`endif

// ---- hdl/pcl_pkg.sv ----
/*
 * Types shared by the current-limit source-select stage.
 * Assumes the register port and sources are synchronous to one clock.
 */
package pcl_pkg;

    // one register access; wr and rd are never high together
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } pcl_bus_req_t;

    // every signal a generator may take as its current-limit source
    typedef struct packed {
        logic [3:0] comparator;
        logic [3:0] shared_fault_input;
        logic       independent_fault_input_2;
        logic       independent_fault_input_4;
    } pcl_src_t;

    // current-limit and fault control register, msb first
    typedef struct packed {
        logic [2:0] unused;
        logic [3:0] limit_source_select;
        logic       limit_polarity;
        logic       limit_mode_enable;
        logic [6:0] fault_fields;
    } pcl_ctrl_t;

endpackage

// ---- hdl/pcl_src_mux.sv ----
/*
 * Picks one current-limit source by its 4-bit select code.
 * Combinational; the caller registers the result.
 */
`timescale 1ns/1ps
`include "pcl_map.svh"

module pcl_src_mux (
    input  pcl_pkg::pcl_src_t i_src,       // all candidate sources
    input  logic [3:0]        i_sel,       // source-select code
    output logic              o_level,     // selected raw level
    output logic              o_reserved   // code is reserved
);
    import pcl_pkg::*;

    always_comb begin
        o_level    = 1'b0;
        o_reserved = 1'b0;
        unique case (i_sel)
            `PCL_SEL_CMP1:  o_level = i_src.comparator[0];
            `PCL_SEL_CMP2:  o_level = i_src.comparator[1];
            `PCL_SEL_CMP3:  o_level = i_src.comparator[2];
            `PCL_SEL_CMP4:  o_level = i_src.comparator[3];
            `PCL_SEL_SHRD1: o_level = i_src.shared_fault_input[0];
            `PCL_SEL_SHRD2: o_level = i_src.shared_fault_input[1];
            `PCL_SEL_SHRD3: o_level = i_src.shared_fault_input[2];
            `PCL_SEL_SHRD4: o_level = i_src.shared_fault_input[3];
            `PCL_SEL_IND2:  o_level = i_src.independent_fault_input_2;
            `PCL_SEL_IND4:  o_level = i_src.independent_fault_input_4;
            default:        o_reserved = 1'b1;
        endcase
    end

endmodule // pcl_src_mux

// ---- hdl/pcl_qualify.sv ----
/*
 * Applies polarity, mode enable and reserved-code blocking to one
 * selected source level. Combinational.
 */
`timescale 1ns/1ps

module pcl_qualify (
    input  logic i_level,     // raw selected level
    input  logic i_polarity,  // 1: source active low
    input  logic i_mode,      // current limiting enabled
    input  logic i_reserved,  // select code is reserved
    output logic o_active     // qualified current-limit request
);

    logic asserted;

    // polarity folded in first so the enable gates a clean active-high term
    assign asserted = i_polarity ? ~i_level : i_level;
    assign o_active = i_mode & ~i_reserved & asserted;

endmodule // pcl_qualify

// ---- hdl/pcl_top.sv ----
/*
 * Current-limit source-select stage for NGEN PWM generators: one control
 * register and one status register per generator, a source mux and a
 * qualifier per generator, and a registered current-limit output.
 * Assumes all inputs synchronous to i_clk and a master that never needs
 * a wait state.
 */
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
`include "pcl_map.svh"

module pcl_top #(
    parameter int NGEN = 4                      // number of generators
) (
    input  logic                 i_clk,         // system clock
    input  logic                 i_rst,         // sync reset, active high
    input  pcl_pkg::pcl_bus_req_t i_bus,        // register request
    input  pcl_pkg::pcl_src_t    i_src,         // candidate sources
    output logic [15:0]          o_rdata,       // read data, one cycle later
    output logic [NGEN-1:0]      o_limit,       // qualified current limit
    output logic [NGEN-1:0]      o_reserved     // reserved code programmed
);
    import pcl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        pcl_ctrl_t [NGEN-1:0] ctrl;
        logic [NGEN-1:0]      level;
        logic [NGEN-1:0]      limit;
        logic [NGEN-1:0]      rsvd;
        logic [NGEN-1:0]      hit;
        logic [15:0]          rdata;
    } pcl_state_t;

    pcl_state_t st_r;
    pcl_state_t st_nxt;

    logic [NGEN-1:0] sel_level;
    logic [NGEN-1:0] sel_rsvd;
    logic [NGEN-1:0] sel_active;

    ////////////////////////////////////////////////////////////////////////
    // address decode, shared by the write and the read paths; status word packing for reads

    function automatic logic addr_is(input logic [7:0] addr,
                                     input logic [7:0] base,
                                     input int         idx);
        logic [7:0] target;
        target = base + 8'(idx);
        return addr == target;
    endfunction

    function automatic logic [15:0] status_word(input logic lvl,
                                                input logic act,
                                                input logic rsv,
                                                input logic hit);
        logic [15:0] w;
        w = 16'h0000;
        w[`PCL_ST_LEVEL]  = lvl;
        w[`PCL_ST_ACTIVE] = act;
        w[`PCL_ST_RSVD]   = rsv;
        w[`PCL_ST_HIT]    = hit;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // per-generator source path

    for (genvar g = 0; g < NGEN; g++) begin : g_gen
        pcl_src_mux u_mux (
            .i_src      (i_src),
            .i_sel      (st_r.ctrl[g].limit_source_select),
            .o_level    (sel_level[g]),
            .o_reserved (sel_rsvd[g])
        );

        pcl_qualify u_qual (
            .i_level    (sel_level[g]),
            .i_polarity (st_r.ctrl[g].limit_polarity),
            .i_mode     (st_r.ctrl[g].limit_mode_enable),
            .i_reserved (sel_rsvd[g]),
            .o_active   (sel_active[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_nxt       = st_r;
        st_nxt.rdata = 16'h0000;

        for (int g = 0; g < NGEN; g++) begin
            // source path results are registered so outputs leave a flop
            st_nxt.level[g] = sel_level[g];
            st_nxt.limit[g] = sel_active[g];
            st_nxt.rsvd[g]  = sel_rsvd[g];

            // control write; top three bits never store
            if (i_bus.wr && addr_is(i_bus.addr, `PCL_CTRL_BASE, g)) begin
                st_nxt.ctrl[g] = pcl_ctrl_t'(i_bus.wdata
                                             & `PCL_CTRL_WMASK);
            end

            // sticky hit: write one clears, a new hit in the same cycle wins
            if (i_bus.wr && addr_is(i_bus.addr, `PCL_STAT_BASE, g)
                && i_bus.wdata[`PCL_ST_HIT]) begin
                st_nxt.hit[g] = 1'b0;
            end
            if (sel_active[g]) begin
                st_nxt.hit[g] = 1'b1;
            end

            // reads; unmapped addresses fall through to zero
            if (i_bus.rd && addr_is(i_bus.addr, `PCL_CTRL_BASE, g)) begin
                st_nxt.rdata = 16'(st_r.ctrl[g]) & `PCL_CTRL_WMASK;
            end
            if (i_bus.rd && addr_is(i_bus.addr, `PCL_STAT_BASE, g)) begin
                st_nxt.rdata = status_word(st_r.level[g], st_r.limit[g],
                                           st_r.rsvd[g], st_r.hit[g]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int g = 0; g < NGEN; g++) begin
                st_r.ctrl[g] <= pcl_ctrl_t'(`PCL_CTRL_RST);
            end
            st_r.level <= '0;
            st_r.limit <= '0;
            st_r.rsvd  <= '0;
            st_r.hit   <= '0;
            st_r.rdata <= 16'h0000;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_rdata    = st_r.rdata;
    assign o_limit    = st_r.limit;
    assign o_reserved = st_r.rsvd;

endmodule // pcl_top

// ---- test/pcl_top_sva.sv ----
/* checks on the current-limit stage ports; shadows generator 0 control.
   assumes one clock, sync reset, reads answered one cycle later. */
`timescale 1ns/1ps
module pcl_top_sva #(
    parameter int NGEN = 4                      // generator count
) (
    input logic                  i_clk,         // clock
    input logic                  i_rst,         // sync reset
    input pcl_pkg::pcl_bus_req_t i_bus,         // register request
    input pcl_pkg::pcl_src_t     i_src,         // candidate sources
    input logic [15:0]           o_rdata,       // read data
    input logic [NGEN-1:0]       o_limit,       // qualified limit
    input logic [NGEN-1:0]       o_reserved     // reserved code flag
);
    import pcl_pkg::*;
    logic [12:0] sh_r;
    logic [3:0]  sel;
    logic        lvl;
    logic        rsv;
    logic        exp_lim;
    assign sel = sh_r[12:9];
    assign rsv = (sel[3:2] == 2'h1) || (sel == 4'hC) || (sel == 4'hE);
    assign lvl = sel[3] ? (sel[2] ? (sel[1] ?
        i_src.independent_fault_input_4 : i_src.independent_fault_input_2)
        : i_src.shared_fault_input[sel[1:0]]) : i_src.comparator[sel[1:0]];
    assign exp_lim = sh_r[7] & ~rsv & (lvl ^ sh_r[8]);
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sh_r <= 13'h0000;
        end else if (i_bus.wr && i_bus.addr == 8'h00) begin
            sh_r <= i_bus.wdata[12:0];
        end
    end
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence rd_ctrl0;
        i_bus.rd && i_bus.addr == 8'h00;
    endsequence
    rsvd_bits_a: assert property (rd_ctrl0 |=> o_rdata[15:13] == 3'h0)
        else $error("control upper bits not zero");
    read_back_a: assert property (rd_ctrl0 |=> o_rdata == {3'h0, sh_r})
        else $error("control read back wrong");
    cmp_route_a: assert property ($past(sel[3:2] == 2'h0)
        |-> o_limit[0] == $past(exp_lim)) else $error("comparator route");
    sfl_route_a: assert property ($past(sel[3:2] == 2'h2)
        |-> o_limit[0] == $past(exp_lim)) else $error("shared fault route");
    ind_route_a: assert property ($past(sel == 4'hD || sel == 4'hF)
        |-> o_limit[0] == $past(exp_lim)) else $error("indep fault route");
    pol_low_a: assert property ($past(sh_r[8:7] == 2'h3 && sel == 4'h0)
        |-> o_limit[0] == !$past(i_src.comparator[0]))
        else $error("low active polarity");
    mode_off_a: assert property ((!sh_r[7])[*2] |-> !o_limit[0])
        else $error("limit while disabled");
    rsvd_code_a: assert property ($past(rsv)
        |-> !o_limit[0] && o_reserved[0]) else $error("reserved code");
    rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 16'h0000)
        else $error("read data outside read cycle");
endmodule // pcl_top_sva
bind pcl_top pcl_top_sva #(.NGEN(NGEN)) u_sva (.i_clk(i_clk), .i_rst(i_rst),
    .i_bus(i_bus), .i_src(i_src), .o_rdata(o_rdata), .o_limit(o_limit),
    .o_reserved(o_reserved));

// ---- test/pcl_src_model.sv ----
/* comparators and fault pins feeding the block.
   assumes levels requested by the bench, synchronous to the clock. */
`timescale 1ns/1ps
module pcl_src_model (
    input  logic              i_clk,   // clock
    input  logic [9:0]        i_set,   // wanted levels, struct bit order
    output pcl_pkg::pcl_src_t o_src    // levels seen by the block
);
    import pcl_pkg::*;
    // pins settle one clock late, as a real comparator would lag
    always_ff @(posedge i_clk) begin
        o_src <= pcl_src_t'(i_set);
    end
endmodule // pcl_src_model

// ---- test/pcl_top_tb.sv ----
/* self-checking bench for the current-limit source-select stage.
   assumes the checker is bound to pcl_top. */
`timescale 1ns/1ps
module pcl_top_tb;
    import pcl_pkg::*;
    logic         i_clk;
    logic         i_rst;
    pcl_bus_req_t bus;
    logic [9:0]   src_set;
    pcl_src_t     src;
    logic [15:0]  rdata;
    logic [3:0]   lim;
    logic [3:0]   rsv;
    int           miscompares;
    int           cmp_count;
    pcl_top #(.NGEN(4)) u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_bus(bus),
        .i_src(src), .o_rdata(rdata), .o_limit(lim), .o_reserved(rsv));
    pcl_src_model u_src (.i_clk(i_clk), .i_set(src_set), .o_src(src));
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////////////
    task close_out;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task chk_rd(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // limit and reserved flag of generator g, once inputs have settled
    task chk_lim(input int g, input logic [1:0] exp);
        repeat (3) @(posedge i_clk);
        #1 cmp_count++;
        if ({lim[g], rsv[g]} !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, {lim[g], rsv[g]},
                     exp);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk);
        bus.wr <= 1'b0;
    endtask
    task rd_reg(input logic [7:0] a, input logic [15:0] exp);
        @(posedge i_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge i_clk);
        bus.rd <= 1'b0;
        #1 chk_rd(rdata, exp);
    endtask
    function automatic int src_bit(input logic [3:0] c);
        if (c < 4'h4) return 6 + c;
        if (c[3:2] == 2'h2) return c - 6;
        if (c == 4'hD) return 1;
        if (c == 4'hF) return 0;
        return -1;
    endfunction
    ////////////////////////////////////////////////////////////////////
    task s_regs;
        rd_reg(8'h00, 16'h0000);
        wr_reg(8'h00, 16'hFFFF);
        rd_reg(8'h00, 16'h1FFF);
        wr_reg(8'h03, 16'hA5A5);
        rd_reg(8'h03, 16'h05A5);
        rd_reg(8'h40, 16'h0000);
    endtask
    task s_codes;
        int b;
        for (int c = 0; c < 16; c++) begin
            b = src_bit(c[3:0]);
            wr_reg(8'h00, {3'h0, c[3:0], 9'h080});
            src_set <= (b < 0) ? 10'h3FF : 10'h001 << b;
            chk_lim(0, {b >= 0, b < 0});
            src_set <= (b < 0) ? 10'h3FF : ~(10'h001 << b);
            chk_lim(0, {1'b0, b < 0});
        end
    endtask
    task s_pol;
        wr_reg(8'h00, 16'h0180);
        src_set <= 10'h000;
        chk_lim(0, 2'h2);
        src_set <= 10'h040;
        chk_lim(0, 2'h0);
    endtask
    task s_mode;
        wr_reg(8'h00, 16'h0000);
        chk_lim(0, 2'h0);
        wr_reg(8'h00, 16'h0080);
        chk_lim(0, 2'h2);
    endtask
    // generators 1 to 3 each follow their own control register
    task s_gens;
        wr_reg(8'h01, 16'h1280);
        wr_reg(8'h02, 16'h0880);
        src_set <= 10'h008;
        chk_lim(1, 2'h2);
        chk_lim(2, 2'h1);
        chk_lim(3, 2'h2);
        src_set <= 10'h100;
        chk_lim(1, 2'h0);
        chk_lim(3, 2'h0);
    endtask
    // status word; a clear in the cycle of a new hit must lose
    task s_stat;
        src_set <= 10'h040;
        chk_lim(0, 2'h2);
        wr_reg(8'h10, 16'h0008);
        rd_reg(8'h10, 16'h000B);
        src_set <= 10'h000;
        chk_lim(0, 2'h0);
        wr_reg(8'h10, 16'h0008);
        rd_reg(8'h10, 16'h0000);
        rd_reg(8'h12, 16'h0004);
    endtask
    initial begin
        i_rst = 1'b1;
        bus = '0;
        src_set = 10'h000;
        miscompares = 0;
        cmp_count = 0;
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        s_regs();
        s_codes();
        s_pol();
        s_mode();
        s_gens();
        s_stat();
        close_out();
    end
endmodule // pcl_top_tb
